// *** hdl/vtiming_pkg.sv ***
//----------------------------------------------------------------------
// Purpose: constants for the vertical video timing block
// Assumes: 16-bit I/O register data, 32-bit I/O addresses
// Notes: offsets are byte addresses on the processor I/O port
//----------------------------------------------------------------------
package vtiming_pkg;

  //--------------------------------------------------------------------
  // Widths
  //--------------------------------------------------------------------
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CTRL_W = 5;

  //--------------------------------------------------------------------
  // Register offsets
  //--------------------------------------------------------------------
  localparam logic [31:0] VSYNC_END_LINE_ADDR = 32'hC0000000;
  localparam logic [31:0] VBLANK_END_LINE_ADDR = 32'hC0000020;
  localparam logic [31:0] VBLANK_START_LINE_ADDR = 32'hC0000040;
  localparam logic [31:0] VERTICAL_TOTAL_LINE_ADDR = 32'hC0000060;
  localparam logic [31:0] DISPLAY_CONTROL_ADDR = 32'hC0000080;
  localparam logic [31:0] TIMING_STATUS_ADDR = 32'hC00000A0;
  localparam logic [31:0] DISPLAY_IRQ_LINE_ADDR = 32'hC0000100;
  localparam logic [31:0] VERTICAL_LINE_COUNTER_ADDR = 32'hC00001C0;
  localparam logic [31:0] VERTICAL_PRESET_VALUE_ADDR = 32'hC0000300;

  //--------------------------------------------------------------------
  // Reset values and control bit positions
  //--------------------------------------------------------------------
  localparam logic [15:0] LINE_RESET = 16'h0000;
  localparam logic [4:0] CTRL_RESET = 5'h07;
  localparam int unsigned CTRL_VSD = 0;
  localparam int unsigned CTRL_CSD = 1;
  localparam int unsigned CTRL_HSD = 2;
  localparam int unsigned CTRL_INTERLACE = 3;
  localparam int unsigned CTRL_COMPOSITE = 4;

  //--------------------------------------------------------------------
  // Sync pin indices and serration timing
  //--------------------------------------------------------------------
  localparam int unsigned PIN_VSYNC = 0;
  localparam int unsigned PIN_COMPOSITE_SYNC_PIN = 1;
  localparam int unsigned PIN_HSYNC = 2;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SERR_MIN_NS = 2000;
  localparam logic [15:0] SERR_MIN_CYCLES =
    16'((SERR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// *** hdl/sync_evt_if.sv ***
//----------------------------------------------------------------------
// Purpose: external sync events from the pin detector to the core
// Assumes: all signals on i_clk
// Notes: edge signals and serr_first are one-cycle pulses, the rest are levels
//----------------------------------------------------------------------
`timescale 1ns/1ps
interface sync_evt_if;
  logic vsync_fall;
  logic composite_sync_pin_fall;
  logic hsync_fall;
  logic serr_first;
  logic vsync_low;
  logic serr_region;
  modport det (output vsync_fall, composite_sync_pin_fall, hsync_fall, serr_first, vsync_low, serr_region);
  modport core (input vsync_fall, composite_sync_pin_fall, hsync_fall, serr_first, vsync_low, serr_region);
endinterface

// *** hdl/ext_sync_detect.sv ***
//----------------------------------------------------------------------
// Purpose: synchronise external sync pins and detect sync events
// Assumes: pins are active low and idle high
// Notes: a composite low pulse of at least SERR_MIN_CYCLES cycles is serration
//----------------------------------------------------------------------
`timescale 1ns/1ps
module ext_sync_detect (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_vsync_pin,
  input wire logic i_composite_sync_pin_pin,
  input wire logic i_hsync_pin,
  sync_evt_if.det evt
);
  import vtiming_pkg::*;

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] pin;
    logic [2:0] prev;
    logic [15:0] low_cnt;
    logic region;
    logic [2:0] fall;
    logic serr_first;
  } det_state_t;

  det_state_t st_reg;
  det_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.meta = {i_hsync_pin, i_composite_sync_pin_pin, i_vsync_pin};
    st_next.pin = st_reg.meta;
    st_next.prev = st_reg.pin;
    st_next.fall = st_reg.prev & ~st_reg.pin;
    st_next.serr_first = 1'b0;
    if (st_reg.pin[PIN_COMPOSITE_SYNC_PIN]) begin
      st_next.low_cnt = 16'h0000;
      // A short pulse after serration closes the serration region
      if (!st_reg.prev[PIN_COMPOSITE_SYNC_PIN] && st_reg.low_cnt < SERR_MIN_CYCLES) begin
        st_next.region = 1'b0;
      end
    end else if (st_reg.low_cnt != 16'hFFFF) begin
      st_next.low_cnt = st_reg.low_cnt + 16'h0001;
      if (st_reg.low_cnt == SERR_MIN_CYCLES - 16'h0001 && !st_reg.region) begin
        st_next.serr_first = 1'b1;
        st_next.region = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '{meta: 3'h7, pin: 3'h7, prev: 3'h7, low_cnt: 16'h0000,
                  region: 1'b0, fall: 3'h0, serr_first: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign evt.vsync_fall = st_reg.fall[PIN_VSYNC];
  assign evt.composite_sync_pin_fall = st_reg.fall[PIN_COMPOSITE_SYNC_PIN];
  assign evt.hsync_fall = st_reg.fall[PIN_HSYNC];
  assign evt.serr_first = st_reg.serr_first;
  assign evt.vsync_low = ~st_reg.pin[PIN_VSYNC];
  assign evt.serr_region = st_reg.region;
endmodule

// *** hdl/vertical_video_timing.sv ***
//----------------------------------------------------------------------
// Purpose: vertical line counter, vertical sync and blanking generation
// Assumes: horizontal logic supplies total and half-total pulses on i_clk
// Notes: i_clk is the video clock; I/O port is the processor access path
//----------------------------------------------------------------------
// What this block does
// - Interrupt when line counter equals interrupt line
// - Video clock counts, clears, reloads line counter
// - Blank ends at end line, total/even-half
// - Blank pin: vblank, or OR with hblank
// - Sync ends at half end line, total/half
// - Sync output returns high at end
// - Second serration ends at full end line, half
// - External sync still active: reload, restart sync
// - Blank starts at start line, total/odd-half
// - External composite or hsync also starts blank
// - At vertical total: start sync, clear counter
// - External vsync or serration: start sync, preset
// - Sync output low at start, line-aligned edges
// - Vertical total is full 16-bit field
// - Counter steps at total, also at half interlaced
// - Clear direction bits enables external sync
//----------------------------------------------------------------------
`timescale 1ns/1ps
module vertical_video_timing (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_h_at_total,
  input wire logic i_h_at_half,
  input wire logic i_hblank,
  input wire logic i_vsync_pin,
  input wire logic i_composite_sync_pin_pin,
  input wire logic i_hsync_pin,
  input wire logic [vtiming_pkg::ADDR_W-1:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [vtiming_pkg::DATA_W-1:0] i_io_wdata,
  output logic [vtiming_pkg::DATA_W-1:0] o_io_rdata,
  output logic o_vsync_n,
  output logic o_vsync_oe,
  output logic o_blank_n,
  output logic o_vblank,
  output logic o_odd_field,
  output logic o_serr_region,
  output logic o_display_irq
);
  import vtiming_pkg::*;

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] vsync_end_line;
    logic [15:0] vblank_end_line;
    logic [15:0] vblank_start_line;
    logic [15:0] vertical_total_line;
    logic [15:0] vertical_line_counter;
    logic [15:0] display_irq_line;
    logic [15:0] vertical_preset_value;
    logic [CTRL_W-1:0] ctrl;
    logic vblank;
    logic vsync;
    logic odd_field;
    logic serr2;
    logic irq;
    logic blank_n;
    logic [15:0] rdata;
  } core_state_t;

  core_state_t st_reg;
  core_state_t st_next;

  function automatic logic [15:0] half_line(input logic [15:0] v);
    return {1'b0, v[15:1]};
  endfunction

  function automatic logic io_hit(input logic [31:0] a, input logic [31:0] reg_addr);
    return a == reg_addr;
  endfunction

  //--------------------------------------------------------------------
  // External sync detection
  //--------------------------------------------------------------------
  sync_evt_if evt ();

  ext_sync_detect u_detect (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_vsync_pin(i_vsync_pin),
    .i_composite_sync_pin_pin(i_composite_sync_pin_pin),
    .i_hsync_pin(i_hsync_pin),
    .evt(evt)
  );

  //--------------------------------------------------------------------
  // Timing conditions
  //--------------------------------------------------------------------
  logic interlace;
  logic h_tick;
  logic ext_v_en;
  logic ext_c_en;
  logic ext_start;
  logic sync_end_hit;
  logic restart;
  logic vertical_total_line_hit;
  logic wr_vertical_line_counter;
  logic blank_end_hit;
  logic blank_start_hit;

  assign interlace = st_reg.ctrl[CTRL_INTERLACE];
  assign h_tick = i_h_at_total | (interlace & i_h_at_half);
  assign ext_v_en = ~st_reg.ctrl[CTRL_VSD];
  assign ext_c_en = ~st_reg.ctrl[CTRL_CSD];
  assign ext_start = (ext_v_en & evt.vsync_fall) | (ext_c_en & evt.serr_first);
  assign sync_end_hit = st_reg.vsync & h_tick
    & (st_reg.vertical_line_counter == half_line(st_reg.vsync_end_line));
  assign restart = sync_end_hit
    & ((ext_v_en & evt.vsync_low) | (ext_c_en & evt.serr_region));
  assign vertical_total_line_hit = h_tick
    & (st_reg.vertical_line_counter == st_reg.vertical_total_line);
  assign wr_vertical_line_counter = i_io_wr & io_hit(i_io_addr, VERTICAL_LINE_COUNTER_ADDR);
  assign blank_end_hit = (st_reg.vertical_line_counter == st_reg.vblank_end_line)
    & (i_h_at_total | (interlace & i_h_at_half & ~st_reg.odd_field));
  assign blank_start_hit = ((st_reg.vertical_line_counter == st_reg.vblank_start_line)
    & (i_h_at_total | (interlace & i_h_at_half & st_reg.odd_field)))
    | (ext_c_en & evt.composite_sync_pin_fall)
    | (~st_reg.ctrl[CTRL_HSD] & evt.hsync_fall);

  //--------------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.irq = 1'b0;

    // Line counter and sync interval
    if (ext_start || restart) begin
      st_next.vsync = 1'b1;
      st_next.vertical_line_counter = st_reg.vertical_preset_value;
    end else if (vertical_total_line_hit) begin
      st_next.vsync = 1'b1;
      st_next.vertical_line_counter = LINE_RESET;
      st_next.serr2 = interlace;
      if (interlace) begin
        st_next.odd_field = ~st_reg.odd_field;
      end
    end else begin
      if (sync_end_hit) begin
        st_next.vsync = 1'b0;
      end
      if (h_tick) begin
        st_next.vertical_line_counter = st_reg.vertical_line_counter + 16'h0001;
      end
    end

    // Second serration region in interlaced video; a new field's set wins over the clear
    if (interlace && i_h_at_half && !vertical_total_line_hit
        && st_reg.vertical_line_counter == st_reg.vsync_end_line) begin
      st_next.serr2 = 1'b0;
    end

    // Vertical blanking, start wins over end
    if (blank_start_hit) begin
      st_next.vblank = 1'b1;
    end else if (blank_end_hit) begin
      st_next.vblank = 1'b0;
    end

    // Processor writes
    if (i_io_wr) begin
      if (io_hit(i_io_addr, VSYNC_END_LINE_ADDR)) begin
        st_next.vsync_end_line = i_io_wdata;
      end
      if (io_hit(i_io_addr, VBLANK_END_LINE_ADDR)) begin
        st_next.vblank_end_line = i_io_wdata;
      end
      if (io_hit(i_io_addr, VBLANK_START_LINE_ADDR)) begin
        st_next.vblank_start_line = i_io_wdata;
      end
      if (io_hit(i_io_addr, VERTICAL_TOTAL_LINE_ADDR)) begin
        st_next.vertical_total_line = i_io_wdata;
      end
      if (io_hit(i_io_addr, DISPLAY_CONTROL_ADDR)) begin
        st_next.ctrl = i_io_wdata[CTRL_W-1:0];
      end
      if (io_hit(i_io_addr, DISPLAY_IRQ_LINE_ADDR)) begin
        st_next.display_irq_line = i_io_wdata;
      end
      if (io_hit(i_io_addr, VERTICAL_PRESET_VALUE_ADDR)) begin
        st_next.vertical_preset_value = i_io_wdata;
      end
    end
    if (wr_vertical_line_counter) begin
      st_next.vertical_line_counter = i_io_wdata;
    end

    // Interrupt only when the counter moves onto the line
    st_next.irq = (st_next.vertical_line_counter == st_reg.display_irq_line)
      && (st_next.vertical_line_counter != st_reg.vertical_line_counter);

    // Shared blank pin
    if (st_reg.ctrl[CTRL_COMPOSITE]) begin
      st_next.blank_n = ~(st_next.vblank | i_hblank);
    end else begin
      st_next.blank_n = ~st_next.vblank;
    end

    // Processor reads
    if (i_io_rd) begin
      case (i_io_addr)
        VSYNC_END_LINE_ADDR: st_next.rdata = st_reg.vsync_end_line;
        VBLANK_END_LINE_ADDR: st_next.rdata = st_reg.vblank_end_line;
        VBLANK_START_LINE_ADDR: st_next.rdata = st_reg.vblank_start_line;
        VERTICAL_TOTAL_LINE_ADDR: st_next.rdata = st_reg.vertical_total_line;
        DISPLAY_CONTROL_ADDR: st_next.rdata = {11'h000, st_reg.ctrl};
        TIMING_STATUS_ADDR: st_next.rdata = {12'h000, st_reg.serr2, st_reg.odd_field,
                                             st_reg.vsync, st_reg.vblank};
        DISPLAY_IRQ_LINE_ADDR: st_next.rdata = st_reg.display_irq_line;
        VERTICAL_LINE_COUNTER_ADDR: st_next.rdata = st_reg.vertical_line_counter;
        VERTICAL_PRESET_VALUE_ADDR: st_next.rdata = st_reg.vertical_preset_value;
        default: st_next.rdata = 16'h0000;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '{vsync_end_line: LINE_RESET, vblank_end_line: LINE_RESET,
                  vblank_start_line: LINE_RESET, vertical_total_line: LINE_RESET,
                  vertical_line_counter: LINE_RESET, display_irq_line: LINE_RESET,
                  vertical_preset_value: LINE_RESET, ctrl: CTRL_RESET,
                  vblank: 1'b0, vsync: 1'b0, odd_field: 1'b0, serr2: 1'b0,
                  irq: 1'b0, blank_n: 1'b1, rdata: 16'h0000};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_io_rdata = st_reg.rdata;
  assign o_vsync_n = ~st_reg.vsync;
  assign o_vsync_oe = st_reg.ctrl[CTRL_VSD];
  assign o_blank_n = st_reg.blank_n;
  assign o_vblank = st_reg.vblank;
  assign o_odd_field = st_reg.odd_field;
  assign o_serr_region = st_reg.serr2;
  assign o_display_irq = st_reg.irq;

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence quiet_s;
    !ext_start && !restart && !wr_vertical_line_counter;
  endsequence

  sequence total_hit_s;
    vertical_total_line_hit ##0 quiet_s;
  endsequence

  sequence sync_end_s;
    sync_end_hit && !vertical_total_line_hit ##0 quiet_s;
  endsequence

  irq_match_a: assert property (
    o_display_irq |-> st_reg.vertical_line_counter == $past(st_reg.display_irq_line))
    else $error("irq without line match");

  irq_once_a: assert property (
    o_display_irq |-> $past(st_reg.vertical_line_counter) != st_reg.vertical_line_counter)
    else $error("irq repeated on same line");

  count_step_a: assert property (
    h_tick && !vertical_total_line_hit ##0 quiet_s |=>
      st_reg.vertical_line_counter == 16'($past(st_reg.vertical_line_counter) + 16'h0001))
    else $error("line counter did not step");

  total_reset_a: assert property (
    total_hit_s |=> st_reg.vertical_line_counter == 16'h0000 && !o_vsync_n ##1 1'b1)
    else $error("vertical total did not start sync");

  sync_end_a: assert property (
    sync_end_s |=> o_vsync_n)
    else $error("sync did not end");

  ext_reload_a: assert property (
    ext_start && !wr_vertical_line_counter |=> !o_vsync_n
      && st_reg.vertical_line_counter == $past(st_reg.vertical_preset_value))
    else $error("external sync did not reload");

  sync_restart_a: assert property (
    restart && !wr_vertical_line_counter |=> !o_vsync_n
      && st_reg.vertical_line_counter == $past(st_reg.vertical_preset_value))
    else $error("sync did not restart");

  blank_start_a: assert property (
    blank_start_hit |=> o_vblank ##0 (o_blank_n == 1'b0))
    else $error("blank did not start");

  blank_end_a: assert property (
    blank_end_hit && !blank_start_hit |=> !o_vblank)
    else $error("blank did not end");

  blank_pin_a: assert property (
    ##1 o_blank_n == !(o_vblank || ($past(st_reg.ctrl[CTRL_COMPOSITE]) && $past(i_hblank))))
    else $error("blank pin wrong");

  serr_end_a: assert property (
    interlace && i_h_at_half && !vertical_total_line_hit
      && st_reg.vertical_line_counter == st_reg.vsync_end_line |=> !o_serr_region)
    else $error("second serration did not end");
endmodule

// *** dv/ext_sync_src.sv ***
//----------------------------------------------------------------------
// Purpose: external video sync source driving the three sync pins
// Assumes: pins are active low and pulled high while idle
// Notes: levels change one nanosecond after a rising clock edge
//----------------------------------------------------------------------
`timescale 1ns/1ps
module ext_sync_src (
  input wire logic i_clk,
  output logic o_vsync_pin,
  output logic o_composite_sync_pin_pin,
  output logic o_hsync_pin
);
  import vtiming_pkg::*;

  logic [2:0] pin_lvl;

  initial begin
    pin_lvl = 3'h7;
  end

  assign o_vsync_pin = pin_lvl[PIN_VSYNC];
  assign o_composite_sync_pin_pin = pin_lvl[PIN_COMPOSITE_SYNC_PIN];
  assign o_hsync_pin = pin_lvl[PIN_HSYNC];

  // Level stays until the caller moves it, so a sync is held past the internal pulse
  task automatic drive_pin(input int unsigned p, input logic v);
    @(posedge i_clk);
    #1;
    pin_lvl[p] = v;
  endtask
endmodule

// *** dv/vertical_video_timing_tb_top.sv ***
//----------------------------------------------------------------------
// Purpose: self-checking bench for the vertical video timing block
// Assumes: inputs move 1 ns after the rising edge of a 5 ns clock
// Notes: a small frame is walked against a reference line model
//----------------------------------------------------------------------
`timescale 1ns/1ps
module vertical_video_timing_tb_top;
  import vtiming_pkg::*;

  localparam logic [31:0] LINE_ADDR [4] = '{VSYNC_END_LINE_ADDR, VBLANK_END_LINE_ADDR,
    VBLANK_START_LINE_ADDR, VERTICAL_TOTAL_LINE_ADDR};
  localparam logic [15:0] LINE_VAL [4] = '{16'h0004, 16'h0003, 16'h0005, 16'h0006};

  logic clk, rstn, h_tot, h_half, hblank, wr, rd;
  logic vs_pin, cs_pin, hs_pin;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, rv;
  logic vsync_n, vsync_oe, blank_n, vblank, odd_field, serr, irq;
  int err_total, checks, irq_seen, irq_e;
  logic [15:0] cnt_e;
  logic vs_e, vb_e;

  vertical_video_timing vertical_video_timing_i (.i_clk(clk), .i_resetn(rstn),
    .i_h_at_total(h_tot), .i_h_at_half(h_half), .i_hblank(hblank),
    .i_vsync_pin(vs_pin), .i_composite_sync_pin_pin(cs_pin), .i_hsync_pin(hs_pin),
    .i_io_addr(addr), .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wdata),
    .o_io_rdata(rdata), .o_vsync_n(vsync_n), .o_vsync_oe(vsync_oe),
    .o_blank_n(blank_n), .o_vblank(vblank), .o_odd_field(odd_field),
    .o_serr_region(serr), .o_display_irq(irq));

  ext_sync_src ext_sync_src_i (.i_clk(clk), .o_vsync_pin(vs_pin), .o_composite_sync_pin_pin(cs_pin),
    .o_hsync_pin(hs_pin));

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (irq === 1'b1) irq_seen <= irq_seen + 1;
  end

  task automatic report_and_stop();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic io_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask

  task automatic io_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    d = rdata;
  endtask

  task automatic h_pulse(input logic t, input logic h);
    @(posedge clk);
    #1;
    h_tot = t;
    h_half = h;
    cyc(1);
    h_tot = 1'b0;
    h_half = 1'b0;
  endtask

  // One full-line step of the reference model, then compare the ports
  task automatic tick();
    logic [15:0] old;
    old = cnt_e;
    if (old == LINE_VAL[3]) begin
      cnt_e = 16'h0000;
      vs_e = 1'b0;
    end else begin
      cnt_e = old + 16'h0001;
    end
    if (old == (LINE_VAL[0] >> 1)) vs_e = 1'b1;
    if (old == LINE_VAL[2]) vb_e = 1'b1;
    else if (old == LINE_VAL[1]) vb_e = 1'b0;
    if (cnt_e == 16'h0004) irq_e++;
    h_pulse(1'b1, 1'b0);
    chk(16'(vsync_n), 16'(vs_e));
    chk(16'(vblank), 16'(vb_e));
    chk(16'(blank_n), 16'(!vb_e));
    io_rd(VERTICAL_LINE_COUNTER_ADDR, rv);
    chk(rv, cnt_e);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      io_rd(LINE_ADDR[i], rv);
      chk(rv, LINE_RESET);
    end
    io_rd(DISPLAY_CONTROL_ADDR, rv);
    chk(rv, 16'(CTRL_RESET));
    io_rd(32'hC0000200, rv);
    chk(rv, 16'h0000);
    chk(16'({vsync_n, vsync_oe, blank_n, vblank, irq}), 16'h001C);
  endtask

  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      io_wr(LINE_ADDR[i], 16'hFFFF - 16'(i));
      io_rd(LINE_ADDR[i], rv);
      chk(rv, 16'hFFFF - 16'(i));
    end
    for (int i = 0; i < 4; i++) io_wr(LINE_ADDR[i], LINE_VAL[i]);
    io_wr(DISPLAY_IRQ_LINE_ADDR, 16'h0004);
  endtask

  task automatic t_frame();
    int base;
    base = irq_seen;
    cnt_e = 16'h0000;
    vs_e = 1'b1;
    vb_e = 1'b0;
    irq_e = 0;
    for (int i = 0; i < 11; i++) tick();
    chk(16'(irq_seen - base), 16'(irq_e));
  endtask

  task automatic t_blank_mix();
    @(posedge clk);
    #1;
    hblank = 1'b1;
    cyc(2);
    chk(16'(blank_n), 16'h0001);
    io_wr(DISPLAY_CONTROL_ADDR, 16'h0017);
    cyc(2);
    chk(16'(blank_n), 16'h0000);
    hblank = 1'b0;
    cyc(2);
    chk(16'(blank_n), 16'h0001);
    io_wr(DISPLAY_CONTROL_ADDR, 16'h0007);
  endtask

  task automatic t_half_tick();
    io_wr(VERTICAL_LINE_COUNTER_ADDR, 16'h000A);
    h_pulse(1'b0, 1'b1);
    io_rd(VERTICAL_LINE_COUNTER_ADDR, rv);
    chk(rv, 16'h000A);
    io_wr(DISPLAY_CONTROL_ADDR, 16'h000F);
    h_pulse(1'b0, 1'b1);
    io_rd(VERTICAL_LINE_COUNTER_ADDR, rv);
    chk(rv, 16'h000B);
    io_wr(DISPLAY_CONTROL_ADDR, 16'h0007);
  endtask

  task automatic t_ext_blank();
    for (int p = 0; p < 2; p++) begin
      io_wr(DISPLAY_CONTROL_ADDR, (p == 0) ? 16'h0005 : 16'h0003);
      io_wr(VERTICAL_LINE_COUNTER_ADDR, 16'h0003);
      h_pulse(1'b1, 1'b0);
      chk(16'(vblank), 16'h0000);
      ext_sync_src_i.drive_pin((p == 0) ? PIN_COMPOSITE_SYNC_PIN : PIN_HSYNC, 1'b0);
      cyc(10);
      ext_sync_src_i.drive_pin((p == 0) ? PIN_COMPOSITE_SYNC_PIN : PIN_HSYNC, 1'b1);
      cyc(2);
      chk(16'(vblank), 16'h0001);
    end
    io_wr(DISPLAY_CONTROL_ADDR, 16'h0007);
  endtask

  task automatic t_ext_vsync();
    io_wr(VERTICAL_PRESET_VALUE_ADDR, 16'h0002);
    io_wr(DISPLAY_CONTROL_ADDR, 16'h0006);
    cyc(2);
    chk(16'(vsync_oe), 16'h0000);
    io_wr(VERTICAL_LINE_COUNTER_ADDR, 16'h000A);
    ext_sync_src_i.drive_pin(PIN_VSYNC, 1'b0);
    cyc(8);
    io_rd(VERTICAL_LINE_COUNTER_ADDR, rv);
    chk(rv, 16'h0002);
    chk(16'(vsync_n), 16'h0000);
    h_pulse(1'b1, 1'b0);
    cyc(3);
    io_rd(VERTICAL_LINE_COUNTER_ADDR, rv);
    chk(rv, 16'h0002);
    chk(16'(vsync_n), 16'h0000);
    ext_sync_src_i.drive_pin(PIN_VSYNC, 1'b1);
    cyc(8);
    h_pulse(1'b1, 1'b0);
    chk(16'(vsync_n), 16'h0001);
    io_rd(VERTICAL_LINE_COUNTER_ADDR, rv);
    chk(rv, 16'h0003);
  endtask

  task automatic t_interlace();
    io_wr(DISPLAY_CONTROL_ADDR, 16'h000F);
    for (int f = 0; f < 2; f++) begin
      io_wr(VERTICAL_LINE_COUNTER_ADDR, LINE_VAL[3]);
      h_pulse(1'b0, 1'b1);
      chk(16'({odd_field, serr, vsync_n}), (f == 0) ? 16'h0006 : 16'h0002);
      io_rd(TIMING_STATUS_ADDR, rv);
      chk(rv & 16'h000E, (f == 0) ? 16'h000E : 16'h000A);
      io_wr(VERTICAL_LINE_COUNTER_ADDR, LINE_VAL[0]);
      h_pulse(1'b0, 1'b1);
      chk(16'(serr), 16'h0000);
    end
    io_wr(DISPLAY_CONTROL_ADDR, 16'h0007);
  endtask

  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    h_tot = 1'b0;
    h_half = 1'b0;
    hblank = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    err_total = 0;
    checks = 0;
    irq_seen = 0;
    repeat (8) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_regs();
    t_frame();
    t_blank_mix();
    t_half_tick();
    t_ext_blank();
    t_ext_vsync();
    t_interlace();
    report_and_stop();
  end
endmodule
